// File: rcc_cause_monitor.sv
// rcc_cause_monitor: port-level timing checks for the reset cause collector
// assumes: bound to rcc_reset_cause_collector; one clock, sync active-low reset
`timescale 1ns/10ps
`default_nettype none
module rcc_cause_monitor (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [rcc_pkg::RCC_ADR_W-1:0] wb_adr_i,
    input wire logic [rcc_pkg::RCC_SEL_W-1:0] wb_sel_i,
    input wire logic [rcc_pkg::RCC_DAT_W-1:0] wb_dat_i,
    input wire logic [rcc_pkg::RCC_DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic power_on_reset_i,
    input wire logic brownout_reset_i,
    input wire logic master_clear_pin_n_i,
    input wire logic reset_instruction_i,
    input wire logic watchdog_timeout_i,
    input wire logic config_mismatch_i,
    input wire logic trap_conflict_i,
    input wire logic illegal_opcode_i,
    input wire logic uninit_wreg_pointer_i,
    input wire logic illegal_addr_mode_i,
    input wire logic security_reset_i,
    input wire logic watchdog_fuse_enable_i,
    input wire logic system_reset_out_o,
    input wire logic regulator_sleep_active_o,
    input wire logic watchdog_enable_o
);
    import rcc_pkg::*;
    logic chip_any;
    logic pin_any;
    logic req;
    logic dat8;
    // source summaries; pins need four samples to pass the synchroniser and output flop
    assign chip_any = reset_instruction_i | watchdog_timeout_i | config_mismatch_i
        | trap_conflict_i | illegal_opcode_i | uninit_wreg_pointer_i
        | illegal_addr_mode_i | security_reset_i;
    assign pin_any = power_on_reset_i | brownout_reset_i | !master_clear_pin_n_i;
    assign req = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
    assign dat8 = wb_dat_i[8];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_out_chip;
        chip_any |=> system_reset_out_o;
    endproperty
    a_out_chip: assert property (p_out_chip)
        else $error("system reset missed an on-chip source");
    property p_out_pin;
        pin_any [*4] |-> system_reset_out_o;
    endproperty
    a_out_pin: assert property (p_out_pin)
        else $error("system reset missed a pin source");
    property p_out_quiet;
        (!pin_any && !chip_any) [*4] |-> !system_reset_out_o;
    endproperty
    a_out_quiet: assert property (p_out_quiet)
        else $error("system reset with no source active");
    property p_ack_time;
        req |=> (wb_ack_o ^ wb_err_o);
    endproperty
    a_ack_time: assert property (p_ack_time)
        else $error("bus request not answered next cycle");
    property p_ack_pulse;
        (wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o);
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus answer longer than one cycle");
    property p_err_map;
        req && wb_adr_i != RCC_ADR_CAUSE && wb_adr_i != RCC_ADR_LEVEL
            |=> wb_err_o && wb_dat_o == 32'h0;
    endproperty
    a_err_map: assert property (p_err_map)
        else $error("unmapped access not refused");
    property p_wdt_fuse;
        watchdog_fuse_enable_i && $past(watchdog_fuse_enable_i) && $past(nrst_i)
            |-> watchdog_enable_o;
    endproperty
    a_wdt_fuse: assert property (p_wdt_fuse)
        else $error("watchdog off while fuse set");
    property p_reg_sleep;
        wb_ack_o && wb_we_i && wb_adr_i == RCC_ADR_CAUSE && wb_sel_i[1] && !power_on_reset_i
            |-> ##2 regulator_sleep_active_o == $past(dat8, 2);
    endproperty
    a_reg_sleep: assert property (p_reg_sleep)
        else $error("regulator control not following written bit");
endmodule // rcc_cause_monitor
bind rcc_reset_cause_collector rcc_cause_monitor rcc_cause_monitor_inst (.*);
`default_nettype wire

// File: rcc_pkg.sv
// rcc_pkg: register map, field positions, reset values and source indices
// assumes: shared by the reset-cause collector and its helpers on one clock
package rcc_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned RCC_ADR_W = 8;
    localparam int unsigned RCC_DAT_W = 32;
    localparam int unsigned RCC_SEL_W = 4;
    localparam int unsigned RCC_REG_W = 16;

    // word offsets of the two registers
    localparam logic [7:0] RCC_ADR_CAUSE = 8'h00;
    localparam logic [7:0] RCC_ADR_LEVEL = 8'h04;

    // ------------------------------------------------------------------
    // reset_cause_control field positions
    // ------------------------------------------------------------------
    localparam int unsigned RCC_B_POWERON = 0;
    localparam int unsigned RCC_B_BROWNOUT = 1;
    localparam int unsigned RCC_B_IDLE = 2;
    localparam int unsigned RCC_B_SLEEP = 3;
    localparam int unsigned RCC_B_WDT_TIMEOUT = 4;
    localparam int unsigned RCC_B_WDT_SOFT_EN = 5;
    localparam int unsigned RCC_B_INSTR = 6;
    localparam int unsigned RCC_B_EXT_PIN = 7;
    localparam int unsigned RCC_B_REG_SLEEP = 8;
    localparam int unsigned RCC_B_CFG_MISMATCH = 9;
    localparam int unsigned RCC_B_ILLEGAL = 14;
    localparam int unsigned RCC_B_TRAP = 15;

    // value after block reset, writable bits, value left by a power-on event
    localparam logic [15:0] RCC_CAUSE_RESET = 16'h0003;
    localparam logic [15:0] RCC_CAUSE_WMASK = 16'hc3ff;
    localparam logic [15:0] RCC_CAUSE_POR = 16'h0001;

    // ------------------------------------------------------------------
    // reset source indices in the level vector
    // ------------------------------------------------------------------
    localparam int unsigned RCC_NSRC = 11;
    localparam int unsigned RCC_S_POWERON = 0;
    localparam int unsigned RCC_S_BROWNOUT = 1;
    localparam int unsigned RCC_S_EXT_PIN = 2;
    localparam int unsigned RCC_S_INSTR = 3;
    localparam int unsigned RCC_S_WDT = 4;
    localparam int unsigned RCC_S_CFG = 5;
    localparam int unsigned RCC_S_TRAP = 6;
    localparam int unsigned RCC_S_ILL_OPCODE = 7;
    localparam int unsigned RCC_S_UNINIT_W = 8;
    localparam int unsigned RCC_S_ILL_ADDR = 9;
    localparam int unsigned RCC_S_SECURITY = 10;
    localparam int unsigned RCC_NPIN = 3;

    // bus answer states
    typedef enum logic [2:0] {
        RCC_BUS_IDLE = 3'b001,
        RCC_BUS_ACK = 3'b010,
        RCC_BUS_ERR = 3'b100
    } rcc_bus_state_t;

endpackage : rcc_pkg

// File: rcc_reset_cause_collector.sv
// rcc_reset_cause_collector: merges reset sources into one system reset and
// keeps a sticky record of each cause in reset_cause_control.
// assumes: one 20 MHz clock, classic wishbone slave, pins are asynchronous
//
// Contract
// RL1 - any active source drives system reset
// RL2 - accept all listed reset sources
// RL3 - each reset sets its own cause flag
// RL4 - power-on clears flags, keeps power-on flag
// RL5 - software sets/clears flags, never resets device
// RL6 - bit 15 records trap conflict reset
// RL7 - bit 14 records illegal opcode/address/W pointer
// RL8 - bit 9 records configuration mismatch reset
// RL9 - bit 8 keeps regulator active in sleep
// RL10 - bit 7 records master clear pin reset
// RL11 - bit 6 records reset instruction executed
// RL12 - bit 5 enables watchdog unless fuse set
// RL13 - bit 4 records watchdog time-out
// RL14 - bit 3 records device was in sleep
// RL15 - bit 2 records device was in idle
// RL16 - system reset forces some state, keeps rest
// RL17 - software clears flags after reading them
// RL18 - bit 1 records brown-out reset
// RL19 - bit 0 records power-on reset
// RL20 - flags accumulate across non power-on resets
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module rcc_reset_cause_collector (
    input wire logic clk_i,
    input wire logic nrst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [rcc_pkg::RCC_ADR_W-1:0] wb_adr_i,
    input wire logic [rcc_pkg::RCC_SEL_W-1:0] wb_sel_i,
    input wire logic [rcc_pkg::RCC_DAT_W-1:0] wb_dat_i,
    output logic [rcc_pkg::RCC_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // asynchronous reset sources
    input wire logic power_on_reset_i,
    input wire logic brownout_reset_i,
    input wire logic master_clear_pin_n_i,
    // on-chip reset sources, same clock, active high levels or pulses
    input wire logic reset_instruction_i,
    input wire logic watchdog_timeout_i,
    input wire logic config_mismatch_i,
    input wire logic trap_conflict_i,
    input wire logic illegal_opcode_i,
    input wire logic uninit_wreg_pointer_i,
    input wire logic illegal_addr_mode_i,
    input wire logic security_reset_i,
    // power-saving mode entries, one-cycle pulses
    input wire logic sleep_entered_i,
    input wire logic idle_entered_i,
    // configuration fuse, static
    input wire logic watchdog_fuse_enable_i,
    // outputs
    output logic system_reset_out_o,
    output logic regulator_sleep_active_o,
    output logic watchdog_enable_o
);
    import rcc_pkg::*;

    // ------------------------------------------------------------------
    // source capture
    // ------------------------------------------------------------------

    logic [RCC_NPIN-1:0] pin_raw;
    logic [RCC_NPIN-1:0] pin_sync;
    logic [RCC_NSRC-1:0] src_level;
    logic [RCC_NSRC-1:0] src_rise;

    // limitation: a pin pulse shorter than one clock can be missed, so pin
    // sources are taken as stretched levels, not as glitches
    // pin is active low, turned round before the synchroniser
    assign pin_raw = {~master_clear_pin_n_i, brownout_reset_i, power_on_reset_i};

    rcc_sync #(
        .WIDTH(RCC_NPIN)
    ) u_pin_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .async_i(pin_raw),
        .sync_o(pin_sync)
    );

    // bit order matches the live-level register read at RCC_ADR_LEVEL
    // one vector of every reset source, pins only after synchronising
    always_comb begin
        src_level = '0;
        src_level[RCC_S_POWERON] = pin_sync[0]; // RL2
        src_level[RCC_S_BROWNOUT] = pin_sync[1]; // RL2
        src_level[RCC_S_EXT_PIN] = pin_sync[2]; // RL2
        src_level[RCC_S_INSTR] = reset_instruction_i; // RL2
        src_level[RCC_S_WDT] = watchdog_timeout_i; // RL2
        src_level[RCC_S_CFG] = config_mismatch_i; // RL2
        src_level[RCC_S_TRAP] = trap_conflict_i; // RL2
        src_level[RCC_S_ILL_OPCODE] = illegal_opcode_i; // RL2
        src_level[RCC_S_UNINIT_W] = uninit_wreg_pointer_i; // RL2
        src_level[RCC_S_ILL_ADDR] = illegal_addr_mode_i; // RL2
        src_level[RCC_S_SECURITY] = security_reset_i; // RL2
    end

    // on-chip sources already run on clk_i and skip the synchroniser
    // each new reset occurrence is one pulse, so a held source counts once
    rcc_rise #(
        .WIDTH(RCC_NSRC)
    ) u_src_rise (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .level_i(src_level),
        .rise_o(src_rise)
    );

    // ------------------------------------------------------------------
    // system reset merge
    // ------------------------------------------------------------------

    logic sys_rst_q;
    logic sys_rst_d;

    // pins reach the output three clocks after they move, on-chip sources one
    // registered so the output never glitches while sources change
    always_comb begin
        sys_rst_d = |src_level; // RL1
    end

    // held high through block reset so nothing downstream starts early
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sys_rst_q <= 1'b1;
        end else begin
            sys_rst_q <= sys_rst_d;
        end
    end

    assign system_reset_out_o = sys_rst_q;

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------

    rcc_bus_state_t bus_q;
    rcc_bus_state_t bus_d;
    logic [RCC_DAT_W-1:0] rdat_q;
    logic [RCC_DAT_W-1:0] rdat_d;
    logic req;
    logic hit_cause;
    logic hit_level;
    logic wr_commit;
    logic [RCC_REG_W-1:0] cause_q;

    assign req = wb_cyc_i & wb_stb_i;
    assign hit_cause = (wb_adr_i == RCC_ADR_CAUSE);
    assign hit_level = (wb_adr_i == RCC_ADR_LEVEL);
    // trade-off: one wait cycle keeps the read mux off the ack path
    // a write lands at the edge where the master sees ack
    assign wr_commit = (bus_q == RCC_BUS_ACK) & req & wb_we_i & hit_cause;

    // one wait cycle, then ack or err for one cycle, then back to idle
    always_comb begin
        bus_d = bus_q;
        rdat_d = rdat_q;
        case (bus_q)
            RCC_BUS_IDLE: begin
                if (req) begin
                    if (hit_cause || hit_level) begin
                        bus_d = RCC_BUS_ACK;
                    end else begin
                        bus_d = RCC_BUS_ERR;
                    end
                    // read data staged now so it is stable under ack
                    if (hit_cause) begin
                        rdat_d = {16'h0000, cause_q};
                    end else if (hit_level) begin
                        rdat_d = {{(RCC_DAT_W-RCC_NSRC){1'b0}}, src_level};
                    end else begin
                        rdat_d = '0;
                    end
                end
            end
            RCC_BUS_ACK: begin
                bus_d = RCC_BUS_IDLE;
            end
            RCC_BUS_ERR: begin
                bus_d = RCC_BUS_IDLE;
            end
            default: begin
                bus_d = RCC_BUS_IDLE;
            end
        endcase
    end

    // state and staged read data move together
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            bus_q <= RCC_BUS_IDLE;
            rdat_q <= '0;
        end else begin
            bus_q <= bus_d;
            rdat_q <= rdat_d;
        end
    end

    // answers come straight from the state, so each stands exactly one cycle
    assign wb_ack_o = (bus_q == RCC_BUS_ACK);
    assign wb_err_o = (bus_q == RCC_BUS_ERR);
    assign wb_dat_o = rdat_q;

    // ------------------------------------------------------------------
    // reset_cause_control register
    // ------------------------------------------------------------------

    logic [RCC_REG_W-1:0] cause_d;
    logic [RCC_REG_W-1:0] wr_lane;
    logic [RCC_REG_W-1:0] hw_set;
    logic [RCC_REG_W-1:0] base;

    // byte enables expanded to bit enables for the low half-word
    assign wr_lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // sleep and idle set on every high cycle: mode flags, not reset events
    // hardware cause events, one bit each
    always_comb begin
        hw_set = '0;
        hw_set[RCC_B_POWERON] = src_rise[RCC_S_POWERON]; // RL19
        hw_set[RCC_B_BROWNOUT] = src_rise[RCC_S_BROWNOUT]; // RL18
        hw_set[RCC_B_IDLE] = idle_entered_i; // RL15
        hw_set[RCC_B_SLEEP] = sleep_entered_i; // RL14
        hw_set[RCC_B_WDT_TIMEOUT] = src_rise[RCC_S_WDT]; // RL13
        hw_set[RCC_B_INSTR] = src_rise[RCC_S_INSTR]; // RL11
        hw_set[RCC_B_EXT_PIN] = src_rise[RCC_S_EXT_PIN]; // RL10
        hw_set[RCC_B_CFG_MISMATCH] = src_rise[RCC_S_CFG]; // RL8
        hw_set[RCC_B_ILLEGAL] = src_rise[RCC_S_ILL_OPCODE]
            | src_rise[RCC_S_UNINIT_W]
            | src_rise[RCC_S_ILL_ADDR]
            | src_rise[RCC_S_SECURITY]; // RL7
        hw_set[RCC_B_TRAP] = src_rise[RCC_S_TRAP]; // RL6
    end

    // priority: power-on wipe, else software write, then warm-reset
    // clear of the soft watchdog enable, and hardware sets on top so an
    // event in the same cycle as a clear is never lost
    always_comb begin
        base = cause_q; // RL20
        if (src_rise[RCC_S_POWERON]) begin
            base = RCC_CAUSE_POR; // RL4
        end else if (wr_commit) begin
            // software may set or clear any flag; the register feeds
            // nothing that causes a reset, so a set here stays a flag
            base = ((cause_q & ~wr_lane) | (wb_dat_i[RCC_REG_W-1:0] & wr_lane))
                & RCC_CAUSE_WMASK; // RL5
        end
        if (sys_rst_q) begin
            base[RCC_B_WDT_SOFT_EN] = 1'b0; // RL16
        end
        cause_d = base | hw_set; // RL3
    end

    // block reset loads the cold-start value: power-on and brown-out seen
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cause_q <= RCC_CAUSE_RESET;
        end else begin
            cause_q <= cause_d;
        end
    end

    // ------------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------------

    logic reg_sleep_q;
    logic reg_sleep_d;
    logic wdt_en_q;
    logic wdt_en_d;

    // fuse high forces the watchdog on whatever software wrote
    // the fuse is a static configuration level, read without a synchroniser
    always_comb begin
        reg_sleep_d = cause_q[RCC_B_REG_SLEEP]; // RL9
        wdt_en_d = watchdog_fuse_enable_i | cause_q[RCC_B_WDT_SOFT_EN]; // RL12
    end

    // both outputs clear during block reset; the watchdog starts off
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            reg_sleep_q <= 1'b0;
            wdt_en_q <= 1'b0;
        end else begin
            reg_sleep_q <= reg_sleep_d;
            wdt_en_q <= wdt_en_d;
        end
    end

    assign regulator_sleep_active_o = reg_sleep_q;
    assign watchdog_enable_o = wdt_en_q;

endmodule // rcc_reset_cause_collector
`default_nettype wire

// File: rcc_reset_cause_collector_bench.sv
// rcc_reset_cause_collector_bench: directed scenarios for the reset cause collector
// assumes: rcc_src_model drives the sources; the checker is bound from its own file
`timescale 1ns/10ps
`default_nettype none
module rcc_reset_cause_collector_bench;
    import rcc_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic fuse = 1'b0;
    logic ack, err, sys_rst, reg_act, wdt_en, master_clear_pin_n;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [12:0] src;
    int err_total = 0;
    int checked = 0;
    int cyc_cnt = 0;
    // flag bit for each source line 1..12
    int unsigned bit_of [1:12] = '{1, 7, 6, 4, 9, 15, 14, 14, 14, 14, 3, 2};
    always #25 clk_i = ~clk_i;
    rcc_src_model rcc_src_model_inst (.clk_i(clk_i), .src_o(src), .master_clear_pin_n_o(master_clear_pin_n));
    rcc_reset_cause_collector rcc_reset_cause_collector_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .power_on_reset_i(src[0]), .brownout_reset_i(src[1]),
        .master_clear_pin_n_i(master_clear_pin_n), .reset_instruction_i(src[3]),
        .watchdog_timeout_i(src[4]), .config_mismatch_i(src[5]), .trap_conflict_i(src[6]),
        .illegal_opcode_i(src[7]), .uninit_wreg_pointer_i(src[8]),
        .illegal_addr_mode_i(src[9]), .security_reset_i(src[10]),
        .sleep_entered_i(src[11]), .idle_entered_i(src[12]),
        .watchdog_fuse_enable_i(fuse), .system_reset_out_o(sys_rst),
        .regulator_sleep_active_o(reg_act), .watchdog_enable_o(wdt_en));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one classic cycle; called just after a rising edge, answer taken at the ack edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic exp_e);
        logic [31:0] q;
        logic e;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, e}, {31'h0, exp_e});
        if (!w) chk(q, exp);
    endtask
    task automatic t_reset();
        bus(1'b0, RCC_ADR_CAUSE, 32'h0, 32'h3, 1'b0);
        bus(1'b0, RCC_ADR_LEVEL, 32'h0, 32'h0, 1'b0);
        bus(1'b1, 8'h08, 32'hffff, 32'h0, 1'b1);
        bus(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
        bus(1'b1, RCC_ADR_CAUSE, 32'h0, 32'h0, 1'b0);
        bus(1'b0, RCC_ADR_CAUSE, 32'h0, 32'h0, 1'b0);
        $display("t_reset done");
    endtask
    // every source line but power-on alone, flag read back then cleared by software
    task automatic t_causes();
        for (int i = 1; i <= 12; i++) begin
            rcc_src_model_inst.fire(i, 4);
            repeat (3) @(posedge clk_i);
            bus(1'b0, RCC_ADR_CAUSE, 32'h0, 32'h1 << bit_of[i], 1'b0);
            bus(1'b1, RCC_ADR_CAUSE, 32'h0, 32'h0, 1'b0);
        end
        $display("t_causes done");
    endtask
    // warm resets stack up; the first one drops the soft watchdog enable
    task automatic t_accum();
        bus(1'b1, RCC_ADR_CAUSE, 32'h20, 32'h0, 1'b0);
        rcc_src_model_inst.fire(6, 2);
        rcc_src_model_inst.fire(4, 1);
        rcc_src_model_inst.fire(2, 4);
        repeat (3) @(posedge clk_i);
        bus(1'b0, RCC_ADR_CAUSE, 32'h0, 32'h8090, 1'b0);
        bus(1'b1, RCC_ADR_CAUSE, 32'h0, 32'h0, 1'b0);
        $display("t_accum done");
    endtask
    // software sets every writable bit: no reset follows, control bits reach the outputs
    task automatic t_soft();
        bus(1'b1, RCC_ADR_CAUSE, 32'hffff_ffff, 32'h0, 1'b0);
        @(negedge clk_i);
        chk({29'h0, sys_rst, reg_act, wdt_en}, 32'h3);
        @(posedge clk_i);
        bus(1'b0, RCC_ADR_CAUSE, 32'h0, 32'hc3ff, 1'b0);
        fuse <= 1'b1;
        bus(1'b1, RCC_ADR_CAUSE, 32'h0, 32'h0, 1'b0);
        @(negedge clk_i);
        chk({29'h0, sys_rst, reg_act, wdt_en}, 32'h1);
        @(posedge clk_i);
        fuse <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        chk({31'h0, wdt_en}, 32'h0);
        @(posedge clk_i);
        $display("t_soft done");
    endtask
    task automatic t_por();
        bus(1'b1, RCC_ADR_CAUSE, 32'h83a4, 32'h0, 1'b0);
        rcc_src_model_inst.fire(0, 4);
        repeat (3) @(posedge clk_i);
        bus(1'b0, RCC_ADR_CAUSE, 32'h0, 32'h1, 1'b0);
        chk({31'h0, reg_act}, 32'h0);
        // upper byte lane only: low flags keep the power-on value
        sel <= 4'h2;
        bus(1'b1, RCC_ADR_CAUSE, 32'hffff, 32'h0, 1'b0);
        sel <= 4'hf;
        bus(1'b0, RCC_ADR_CAUSE, 32'h0, 32'hc301, 1'b0);
        $display("t_por done");
    endtask
    task automatic end_sim();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            err_total++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_causes();
        t_accum();
        t_soft();
        t_por();
        end_sim();
    end
endmodule // rcc_reset_cause_collector_bench
`default_nettype wire

// File: rcc_rise.sv
// rcc_rise: rising-edge detector per bit, one-cycle pulse out
// assumes: inputs already on clk_i; a level high across reset gives a pulse
`timescale 1ns/10ps
`default_nettype none
module rcc_rise #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] level_i,
    output logic [WIDTH-1:0] rise_o
);
    // ------------------------------------------------------------------
    // per-bit history flop
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic prev_q;
            logic prev_d;
            always_comb begin
                prev_d = level_i[g];
            end
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    prev_q <= 1'b0;
                end else begin
                    prev_q <= prev_d;
                end
            end
            assign rise_o[g] = level_i[g] & ~prev_q;
        end
    endgenerate
endmodule // rcc_rise
`default_nettype wire

// File: rcc_src_model.sv
// rcc_src_model: reset sources and power-state pulses facing the collector
// assumes: same clock as the design; the bench calls fire() just after an edge
`timescale 1ns/10ps
`default_nettype none
module rcc_src_model (
    input wire logic clk_i,
    output logic [12:0] src_o,
    output logic master_clear_pin_n_o
);
    logic [12:0] lvl_q = 13'h0000;
    // pin reset is active low, every other line active high
    assign src_o = lvl_q;
    assign master_clear_pin_n_o = ~lvl_q[2];
    // hold one line for n cycles; pins need one or more to pass the sync
    task automatic fire(input int idx, input int n);
        lvl_q[idx] <= 1'b1;
        repeat (n) @(posedge clk_i);
        lvl_q[idx] <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule // rcc_src_model
`default_nettype wire

// File: rcc_sync.sv
// rcc_sync: two-flop synchroniser, one pair per bit
// assumes: inputs are asynchronous pins, reset is synchronous active low
`timescale 1ns/10ps
`default_nettype none
module rcc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    // ------------------------------------------------------------------
    // per-bit flop pair
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta_q;
            logic meta_d;
            logic stab_q;
            logic stab_d;
            // first flop feeds only the second
            always_comb begin
                meta_d = async_i[g];
                stab_d = meta_q;
            end
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    meta_q <= 1'b0;
                    stab_q <= 1'b0;
                end else begin
                    meta_q <= meta_d;
                    stab_q <= stab_d;
                end
            end
            assign sync_o[g] = stab_q;
        end
    endgenerate
endmodule // rcc_sync
`default_nettype wire
